// ==== dv/sensor_spi_register_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_regs.svh"

module sensor_spi_register_port_bench;
  logic        clk, nrst, wire_mode_select;
  logic [13:0] angle_sample, a, d;
  logic [5:0]  g;
  logic [31:0] seed, r;
  logic [15:0] rx;
  int          fails, tests_run;
  wire         sclk, frame_select_n, mosi, sdio_in, miso, miso_oe, sdio_out, sdio_oe;
  wire         result_ready_n, por_detector_off;
  wire [5:0]   gain_loop_value;
  wire [1:0]   gain_setting;
  localparam logic [15:0] F = 16'hFFFF;
  localparam logic [15:0] N = 16'h0000;
  localparam logic [15:0] E = 16'h0002;

  ssrp_top DUT (.clk(clk), .nrst(nrst), .sclk(sclk), .frame_select_n(frame_select_n),
    .wire_mode_select(wire_mode_select), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .angle_sample(angle_sample), .result_ready_n(result_ready_n),
    .por_detector_off(por_detector_off), .gain_loop_value(gain_loop_value),
    .gain_setting(gain_setting));

  ssrp_host_model host (.sclk(sclk), .frame_select_n(frame_select_n), .mosi(mosi),
    .sdio_in(sdio_in), .miso(miso), .miso_oe(miso_oe), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .four_wire(wire_mode_select));

  always #2 clk = ~clk;

  // ==========================================================
  // Frame builders and stimulus source
  function automatic logic [15:0] pw(input logic [14:0] u);
    return {u, ^u};
  endfunction
  function automatic logic [15:0] rd(input logic [13:0] ad);
    return pw({1'b1, ad});
  endfunction
  function automatic logic [15:0] wr(input logic [13:0] ad);
    return pw({1'b0, ad});
  endfunction
  function automatic logic [15:0] dw(input logic [13:0] dd, input logic b1);
    return pw({dd, b1});
  endfunction
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fr(input logic [15:0] tx, input int nb, input logic lis,
                    input logic [15:0] ex, input logic [15:0] m);
    host.xfer(tx, nb, lis, rx);
    if (m != N) check(rx & m, ex & m);
    check({14'h0000, miso_oe, sdio_oe}, N);
  endtask
  task automatic f(input logic [15:0] tx, input logic [15:0] ex, input logic [15:0] m);
    fr(tx, 16, 1'b0, ex, m);
  endtask
  // Bounded wait; the conversion takes 125 cycles
  task automatic wait_ready();
    int n;
    n = 0;
    while (result_ready_n !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      finish_test();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    fails = 0;
    tests_run = 0;
    seed = 32'h00000021;
    nrst = 1'b1;
    wire_mode_select = 1'b1;
    angle_sample = 14'h0000;
    // Clean falling edge so every asynchronous reset branch sees it
    #1;
    nrst = 1'b0;
    @(posedge clk);
    #1;
    check({15'h0000, result_ready_n}, 16'h0001);
    check({10'h000, gain_loop_value}, {10'h000, `SSRP_GAIN_RST});
    check({15'h0000, por_detector_off}, N);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_ready();
    r = rnd();
    g = {r[5:1], 1'b1};
    d = r[19:6];
    f(wr(`SSRP_ADDR_GAIN), N, N);
    f(dw({8'h00, g}, r[0]), dw(14'h0020, 1'b0), F);
    check({10'h000, gain_loop_value}, {10'h000, g});
    f(wr(`SSRP_ADDR_SYS_CFG), dw({8'h00, g}, 1'b0), F);
    f(dw(d, r[20]), dw(`SSRP_SYSCFG_RST, 1'b0), F);
    f(rd(`SSRP_ADDR_ERR_STAT), dw({5'h05, d[8:0]}, 1'b0), F);
    check({14'h0000, gain_setting}, {14'h0000, d[4:3]});
    f(rd(`SSRP_ADDR_GAIN), N, F);
    r = rnd();
    a = r[13:0];
    @(posedge clk);
    angle_sample <= a;
    f(rd(`SSRP_ADDR_ANGLE), dw({8'h00, g}, 1'b0), F);
    check({15'h0000, result_ready_n}, 16'h0001);
    wait_ready();
    f(rd(`SSRP_ADDR_ANGLE), N, F);
    wait_ready();
    f(rd(`SSRP_ADDR_CLR_ERR), dw(a, 1'b0), F);
    // Parity fault, unknown command, short frame
    for (int i = 0; i < 3; i++) begin
      fr((i == 1) ? rd(`SSRP_ADDR_SOFT_RST) : rd(`SSRP_ADDR_GAIN) ^ {15'h0000, i == 0},
         (i == 2) ? 12 : 16, 1'b0, (i == 0) ? N : dw({8'h00, g}, 1'b0),
         (i == 2) ? 16'hFFF0 : F);
      f(rd(`SSRP_ADDR_ERR_STAT), E, E);
      f(rd(`SSRP_ADDR_CLR_ERR), dw(14'h0001 << i, 1'b1), F);
      f(rd(`SSRP_ADDR_GAIN), N, F);
    end
    f(wr(`SSRP_ADDR_POR_OFF), dw({8'h00, g}, 1'b0), F);
    f(dw({6'h00, `SSRP_POR_OFF_KEY}, 1'b0), N, F);
    check({15'h0000, por_detector_off}, 16'h0001);
    f(rd(`SSRP_ADDR_GAIN) ^ 16'h0001, dw({6'h00, `SSRP_POR_OFF_KEY}, 1'b0), F);
    r = rnd();
    f(wr(`SSRP_ADDR_SOFT_RST), N, N);
    @(posedge clk);
    angle_sample <= ~a;
    // Upper bits random: they must be ignored
    f(dw({r[12:0], 1'b1}, r[13]), N, N);
    check({10'h000, gain_loop_value}, 16'h0020);
    check({15'h0000, por_detector_off}, N);
    check({15'h0000, result_ready_n}, 16'h0001);
    wait_ready();
    f(rd(`SSRP_ADDR_ERR_STAT), N, N);
    f(rd(`SSRP_ADDR_ANGLE), N, F);
    f(rd(`SSRP_ADDR_GAIN), dw(a, 1'b0), F);
    wait_ready();
    f(wr(`SSRP_ADDR_GAIN), dw(14'h0020, 1'b0), F);
    f(dw({8'h00, g}, 1'b0), dw(14'h0020, 1'b0), F);
    f(wr(`SSRP_ADDR_FULL_RST), dw({8'h00, g}, 1'b0), F);
    check({10'h000, gain_loop_value}, 16'h0020);
    check({15'h0000, result_ready_n}, 16'h0001);
    wait_ready();
    @(posedge clk);
    wire_mode_select <= 1'b0;
    repeat (4) @(posedge clk);
    f(rd(`SSRP_ADDR_GAIN), N, N);
    fr(N, 16, 1'b1, dw(14'h0020, 1'b0), F);
    finish_test();
  end
endmodule // sensor_spi_register_port_bench

`default_nettype wire

// ==== dv/ssrp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host master of the serial link, mode 1
module ssrp_host_model (
  // Link pins
  output var  logic sclk,
  output var  logic frame_select_n,
  output var  logic mosi,
  output var  logic sdio_in,
  // Device outputs and wire mode
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic four_wire
);
  logic bit_out;

  // Shared pin: device wins while enabled, else the host bit, inverted once each frame ends
  assign sdio_in = sdio_oe ? sdio_out : bit_out;
  assign mosi    = bit_out;

  // Short idle pulse gives the select line a clean rising edge at start
  initial begin
    sclk = 1'b0;
    frame_select_n = 1'b0;
    bit_out = 1'b1;
    #1;
    frame_select_n = 1'b1;
  end

  // ==========================================================
  // One frame; clock stands low outside it; nb below 16 is a bad count
  task automatic xfer(input logic [15:0] tx, input int nb, input logic listen,
                      output logic [15:0] rx);
    rx = 16'hXXXX;
    frame_select_n = 1'b0;
    #60;
    for (int k = 0; k < nb; k++) begin
      sclk = 1'b1;
      if (!listen) bit_out = tx[15-k];
      #24;
      sclk = 1'b0;
      // Undriven data line reads unknown so a release is never mistaken for data
      if (four_wire) rx[15-k] = miso_oe ? miso : 1'bx;
      else rx[15-k] = sdio_oe ? sdio_out : 1'bx;
      #24;
    end
    #36;
    frame_select_n = 1'b1;
    bit_out = ~bit_out;
    #100;
  endtask
endmodule // ssrp_host_model

`default_nettype wire

// ==== hdl/ssrp_link.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssrp_link (
  // Reset and link clock
  input  wire logic        nrst,
  input  wire logic        sclk,
  input  wire logic        frame_select_n,
  // Serial data
  input  wire logic        mosi,
  input  wire logic        sdio_in,
  output var  logic        miso,
  output var  logic        miso_oe,
  output var  logic        sdio_out,
  output var  logic        sdio_oe,
  // Core side, quasi-static across a frame
  input  wire logic        mode4,
  input  wire logic        out3,
  input  wire logic [15:0] tx_word,
  output var  logic [15:0] rx_word,
  output var  logic [4:0]  rx_bits,
  output var  logic        frame_tg
);

  logic fresh_reg;
  logic din;
  logic tx_bit;

  assign din    = mode4 ? mosi : sdio_in;
  assign tx_bit = fresh_reg ? tx_word[15] :
                  (rx_bits[4] ? 1'b0 : tx_word[4'hF - rx_bits[3:0]]);

  // ==========================================================
  // Frame start marker, preset by the idle select line
  always_ff @(negedge sclk or posedge frame_select_n) begin
    if (frame_select_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Receive on falling edge, MSB first; count kept after frame
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      rx_word  <= 16'h0000;
      rx_bits  <= 5'h00;
      frame_tg <= 1'b0;
    end else begin
      rx_word <= {rx_word[14:0], din};
      if (fresh_reg) begin
        rx_bits  <= 5'h01;
        frame_tg <= ~frame_tg;
      end else if (rx_bits != 5'h1F) begin
        rx_bits <= rx_bits + 5'h01;
      end
    end
  end

  // ==========================================================
  // Transmit on rising edge so data is stable at the falling one
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      miso     <= 1'b0;
      sdio_out <= 1'b0;
    end else begin
      miso     <= tx_bit;
      sdio_out <= tx_bit;
    end
  end

  // Drivers drop as soon as the select line rises
  always_ff @(posedge sclk or posedge frame_select_n) begin
    if (frame_select_n) begin
      miso_oe <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      miso_oe <= mode4;
      sdio_oe <= ~mode4 & out3;
    end
  end

endmodule // ssrp_link

`default_nettype wire

// ==== hdl/ssrp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_regs.svh"

// Operation
// - Wire mode pin low three-wire, high four-wire
// - Command frame then data frame, 16 bits each
// - Bad command parity sets parity fault status
// - Reply frame: data, error flag, even parity
// - Reply error flag shows previous command error
// - Register sampled at frame end, sent next frame
// - Write echoes old contents, then new contents; no echo in three-wire mode
// - Key 0x5A at detector register disables detector
// - Write to soft reset register resets device
// - Bit 2 set also resets serial registers
// - Reset starts hidden angle conversion
// - Result-ready output low signals readiness
// - Full reset acts alike, no data frame
// - Mode 1: falling sample, MSB first, execute at end
// - Angle fetch raises busy, measures, then drops
// - Error flag set on faults, sticky until cleared
// - Clear-error read clears flag, returns zero
module ssrp_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        frame_select_n,
  input  wire logic        wire_mode_select,
  input  wire logic        mosi,
  output var  logic        miso,
  output var  logic        miso_oe,
  input  wire logic        sdio_in,
  output var  logic        sdio_out,
  output var  logic        sdio_oe,
  // Measurement chain
  input  wire logic [13:0] angle_sample,
  output var  logic        result_ready_n,
  output var  logic        por_detector_off,
  output var  logic [5:0]  gain_loop_value,
  output var  logic [1:0]  gain_setting
);
  import ssrp_pkg::*;

  localparam int MEAS_GAP = `SSRP_MEAS_CYC - 7;

  ssrp_core_t  r_reg;
  ssrp_core_t  r_next;
  logic        rst_s1_reg;
  logic        rst_s2_reg;
  logic [15:0] rx_word;
  logic [4:0]  rx_bits;
  logic        frame_tg;
  logic        frame_end;
  logic        seen;
  logic        len_ok;
  logic        par_ok;
  logic        good;
  logic        cmd_rd;
  logic [13:0] cmd_addr;
  logic        known;
  logic [13:0] wdata;
  logic [13:0] echo_val;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // ==========================================================
  // Link side
  ssrp_link u_link (
    .nrst           (nrst),
    .sclk           (sclk),
    .frame_select_n (frame_select_n),
    .mosi           (mosi),
    .sdio_in        (sdio_in),
    .miso           (miso),
    .miso_oe        (miso_oe),
    .sdio_out       (sdio_out),
    .sdio_oe        (sdio_oe),
    .mode4          (r_reg.mode4),
    .out3           (r_reg.drive3),
    .tx_word        (r_reg.tx_word),
    .rx_word        (rx_word),
    .rx_bits        (rx_bits),
    .frame_tg       (frame_tg)
  );

  // ==========================================================
  // Frame decode; link words are stable once the select line is high
  assign frame_end = r_reg.cs_s2 & ~r_reg.cs_s3;
  assign seen      = r_reg.tg_s2 != r_reg.tg_seen;
  assign len_ok    = rx_bits == `SSRP_FRAME_BITS;
  assign par_ok    = ~(^rx_word);
  assign good      = frame_end & seen & len_ok & par_ok;
  assign cmd_rd    = rx_word[`SSRP_BIT_DIR];
  assign cmd_addr  = rx_word[14:1];
  assign wdata     = rx_word[15:2];

  always_comb begin
    unique case (cmd_addr)
      `SSRP_ADDR_NOP,
      `SSRP_ADDR_SYS_CFG,
      `SSRP_ADDR_POR_OFF,
      `SSRP_ADDR_GAIN:       known = 1'b1;
      `SSRP_ADDR_ERR_STAT,
      `SSRP_ADDR_CLR_ERR,
      `SSRP_ADDR_ANGLE:      known = cmd_rd;
      `SSRP_ADDR_FULL_RST,
      `SSRP_ADDR_SOFT_RST:   known = ~cmd_rd;
      default:               known = 1'b0;
    endcase
  end

  // Reply word with even parity over the upper fifteen bits
  function automatic logic [15:0] mk_frame(input logic [13:0] d, input logic e);
    mk_frame = {d, e, ^{d, e}};
  endfunction

  function automatic logic [13:0] rd_val(input ssrp_core_t s, input logic [13:0] a);
    unique case (a)
      `SSRP_ADDR_ERR_STAT: rd_val = {10'h000, s.pending, s.err_clk, s.err_cmd, s.err_par};
      `SSRP_ADDR_SYS_CFG:  rd_val = s.syscfg;
      `SSRP_ADDR_POR_OFF:  rd_val = {6'h00, s.por_off};
      `SSRP_ADDR_GAIN:     rd_val = {8'h00, s.gain};
      `SSRP_ADDR_ANGLE:    rd_val = s.angle;
      default:             rd_val = 14'h0000;
    endcase
  endfunction

  // ==========================================================
  // Core next state
  always_comb begin
    r_next       = r_reg;
    r_next.cs_s1 = frame_select_n;
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.cs_s3 = r_reg.cs_s2;
    r_next.tg_s1 = frame_tg;
    r_next.tg_s2 = r_reg.tg_s1;
    r_next.wm_s1 = wire_mode_select;
    r_next.wm_s2 = r_reg.wm_s1;
    r_next.mode4 = r_reg.wm_s2;
    r_next.por_det_off = r_reg.por_off == `SSRP_POR_OFF_KEY;

    // Conversion; a reset conversion never reaches the result register
    if (r_reg.pending) begin
      if (r_reg.meas_cnt == 8'h00) begin
        r_next.pending = 1'b0;
        r_next.busy    = 1'b0;
        r_next.hide    = 1'b0;
        if (!r_reg.hide) begin
          r_next.angle = angle_sample;
        end
      end else begin
        r_next.meas_cnt = r_reg.meas_cnt - 8'h01;
      end
    end

    // Commands run only when the frame closes
    if (frame_end) begin
      r_next.tg_seen = r_reg.tg_s2;
      if (!seen) begin
        r_next.state = r_reg.state;
      end else if (!len_ok) begin
        r_next.ef      = 1'b1;
        r_next.err_clk = 1'b1;
        r_next.state   = st_cmd;
        r_next.tx_word = mk_frame(14'h0000, 1'b1);
      end else begin
        unique case (r_reg.state)
          st_cmd: begin
            if (!par_ok) begin
              r_next.ef      = 1'b1;
              r_next.err_par = 1'b1;
              r_next.tx_word = mk_frame(14'h0000, 1'b1);
            end else if (!known) begin
              r_next.ef      = 1'b1;
              r_next.err_cmd = 1'b1;
              r_next.tx_word = mk_frame(14'h0000, 1'b1);
            end else if (cmd_rd) begin
              if (cmd_addr == `SSRP_ADDR_CLR_ERR) begin
                r_next.ef      = 1'b0;
                r_next.err_par = 1'b0;
                r_next.err_cmd = 1'b0;
                r_next.err_clk = 1'b0;
                r_next.tx_word = mk_frame(14'h0000, 1'b0);
              end else begin
                r_next.tx_word = mk_frame(rd_val(r_reg, cmd_addr), r_reg.ef);
              end
              if (cmd_addr == `SSRP_ADDR_ANGLE) begin
                r_next.pending  = 1'b1;
                r_next.busy     = 1'b1;
                r_next.hide     = 1'b0;
                r_next.meas_cnt = 8'(`SSRP_MEAS_CYC - 1);
              end
              // Three-wire: the reply frame leaves the shared pin to us
              if (!r_reg.mode4) begin
                r_next.state = st_reply;
              end
            end else if (cmd_addr == `SSRP_ADDR_FULL_RST) begin
              r_next.gain     = `SSRP_GAIN_RST;
              r_next.por_off  = `SSRP_POR_RST;
              r_next.pending  = 1'b1;
              r_next.busy     = 1'b1;
              r_next.hide     = 1'b1;
              r_next.meas_cnt = 8'(`SSRP_MEAS_CYC - 1);
              r_next.state    = st_cmd;
              r_next.tx_word  = mk_frame(14'h0000, r_reg.ef);
            end else begin
              r_next.addr    = cmd_addr;
              r_next.tx_word = mk_frame(rd_val(r_reg, cmd_addr), r_reg.ef);
              r_next.state   = st_wdata;
            end
          end
          st_wdata: begin
            r_next.state = st_cmd;
            if (!par_ok) begin
              r_next.ef      = 1'b1;
              r_next.err_par = 1'b1;
              r_next.tx_word = mk_frame(14'h0000, 1'b1);
            end else begin
              unique case (r_reg.addr)
                `SSRP_ADDR_SYS_CFG: r_next.syscfg  = {r_reg.syscfg[13:9], wdata[8:0]};
                `SSRP_ADDR_POR_OFF: r_next.por_off = wdata[7:0];
                `SSRP_ADDR_GAIN:    r_next.gain    = wdata[5:0];
                default:            r_next.gain    = r_reg.gain;
              endcase
              r_next.tx_word = mk_frame(rd_val(r_next, r_reg.addr), r_reg.ef);
              if (r_reg.addr == `SSRP_ADDR_SOFT_RST) begin
                r_next.gain     = `SSRP_GAIN_RST;
                r_next.por_off  = `SSRP_POR_RST;
                r_next.pending  = 1'b1;
                r_next.busy     = 1'b1;
                r_next.hide     = 1'b1;
                r_next.meas_cnt = 8'(`SSRP_MEAS_CYC - 1);
                r_next.tx_word  = mk_frame(14'h0000, r_reg.ef);
                if (rx_word[`SSRP_BIT_SPI_RST]) begin
                  r_next.ef      = 1'b0;
                  r_next.err_par = 1'b0;
                  r_next.err_cmd = 1'b0;
                  r_next.err_clk = 1'b0;
                  r_next.tx_word = 16'h0000;
                end
              end
            end
          end
          st_reply: begin
            r_next.state = st_cmd;
          end
        endcase
      end
    end
    r_next.drive3 = r_next.state == st_reply;
  end

  // ==========================================================
  // Core registers; power-up runs one hidden conversion
  always_ff @(posedge clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      r_reg          <= '0;
      r_reg.cs_s1    <= 1'b1;
      r_reg.cs_s2    <= 1'b1;
      r_reg.cs_s3    <= 1'b1;
      r_reg.wm_s1    <= 1'b1;
      r_reg.wm_s2    <= 1'b1;
      r_reg.mode4    <= 1'b1;
      r_reg.state    <= st_cmd;
      r_reg.pending  <= 1'b1;
      r_reg.busy     <= 1'b1;
      r_reg.hide     <= 1'b1;
      r_reg.meas_cnt <= 8'(`SSRP_MEAS_CYC - 1);
      r_reg.gain     <= `SSRP_GAIN_RST;
      r_reg.syscfg   <= `SSRP_SYSCFG_RST;
      r_reg.por_off  <= `SSRP_POR_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign result_ready_n   = r_reg.busy;
  assign por_detector_off = r_reg.por_det_off;
  assign gain_loop_value  = r_reg.gain;
  assign gain_setting     = r_reg.syscfg[4:3];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s2_reg);

  // Echo source as a plain signal, so the check can look one edge back
  assign echo_val = rd_val(r_reg, cmd_addr);

  sequence s_fetch;
    good && r_reg.state == st_cmd && cmd_rd && cmd_addr == `SSRP_ADDR_ANGLE;
  endsequence

  sequence s_busy_run;
    r_reg.busy [*8];
  endsequence

  sequence s_soft;
    good && r_reg.state == st_wdata && r_reg.addr == `SSRP_ADDR_SOFT_RST;
  endsequence

  a_parity_fault: assert property (
    frame_end && seen && len_ok && !par_ok && r_reg.state == st_cmd
    |=> r_reg.err_par && r_reg.ef && r_reg.tx_word[`SSRP_BIT_EF])
    else $error("parity fault not flagged");

  a_reply_parity: assert property (!(^r_reg.tx_word))
    else $error("reply frame parity odd");

  a_ef_sticky: assert property ($fell(r_reg.ef) |-> $past(good))
    else $error("error flag cleared without command");

  a_clear_reply: assert property (
    good && r_reg.state == st_cmd && cmd_rd && cmd_addr == `SSRP_ADDR_CLR_ERR
    |=> !r_reg.ef && r_reg.tx_word == 16'h0000)
    else $error("clear error reply wrong");

  a_write_phase: assert property (
    good && known && r_reg.state == st_cmd && !cmd_rd && cmd_addr != `SSRP_ADDR_FULL_RST
    |=> r_reg.state == st_wdata && r_reg.tx_word[15:2] == $past(echo_val))
    else $error("write echo wrong");

  a_fetch_timing: assert property (
    s_fetch |=> s_busy_run ##[MEAS_GAP:MEAS_GAP] !r_reg.busy)
    else $error("measurement timing wrong");

  a_por_key: assert property (
    good && r_reg.state == st_wdata && r_reg.addr == `SSRP_ADDR_POR_OFF
    && wdata[7:0] == `SSRP_POR_OFF_KEY |=> ##1 por_detector_off)
    else $error("detector not switched off");

  a_soft_reset: assert property (s_soft |=> r_reg.pending && r_reg.hide && result_ready_n)
    else $error("soft reset conversion not started");

  a_spi_reset: assert property (
    s_soft ##0 rx_word[`SSRP_BIT_SPI_RST] |=> !r_reg.ef && !r_reg.err_par)
    else $error("serial registers not reset");

  a_full_reset: assert property (
    good && r_reg.state == st_cmd && !cmd_rd && cmd_addr == `SSRP_ADDR_FULL_RST
    |=> r_reg.state == st_cmd && r_reg.hide && r_reg.gain == `SSRP_GAIN_RST)
    else $error("full reset wrong");

endmodule // ssrp_top

`default_nettype wire

// ==== include/ssrp_pkg.sv ====
package ssrp_pkg;

  // ==========================================================
  // Frame phase of the serial protocol
  typedef enum logic [1:0] {
    st_cmd,
    st_wdata,
    st_reply
  } ssrp_state_t;

  // ==========================================================
  // Whole state of the core clock domain
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_s3;
    logic        tg_s1;
    logic        tg_s2;
    logic        tg_seen;
    logic        wm_s1;
    logic        wm_s2;
    logic        mode4;
    ssrp_state_t state;
    logic [13:0] addr;
    logic [15:0] tx_word;
    logic        drive3;
    logic        ef;
    logic        err_par;
    logic        err_cmd;
    logic        err_clk;
    logic        pending;
    logic        busy;
    logic        hide;
    logic [7:0]  meas_cnt;
    logic [13:0] angle;
    logic [5:0]  gain;
    logic [13:0] syscfg;
    logic [7:0]  por_off;
    logic        por_det_off;
  } ssrp_core_t;

endpackage

// ==== include/ssrp_regs.svh ====
`ifndef SSRP_REGS_SVH
`define SSRP_REGS_SVH

// ==========================================================
// Register addresses
`define SSRP_ADDR_NOP        14'h0000
`define SSRP_ADDR_ERR_STAT   14'h335A
`define SSRP_ADDR_CLR_ERR    14'h3380
`define SSRP_ADDR_FULL_RST   14'h33A5
`define SSRP_ADDR_SOFT_RST   14'h3C00
`define SSRP_ADDR_SYS_CFG    14'h3F20
`define SSRP_ADDR_POR_OFF    14'h3F22
`define SSRP_ADDR_GAIN       14'h3FF8
`define SSRP_ADDR_ANGLE      14'h3FFF

// ==========================================================
// Frame and field positions
`define SSRP_FRAME_BITS      5'h10
`define SSRP_BIT_DIR         15
`define SSRP_BIT_EF          1
`define SSRP_BIT_SPI_RST     2
`define SSRP_ERR_PAR         0
`define SSRP_ERR_CMD         1
`define SSRP_ERR_CLK         2
`define SSRP_ERR_PEND        3
`define SSRP_POR_OFF_KEY     8'h5A

// ==========================================================
// Reset values; chip id field value is arbitrary
`define SSRP_GAIN_RST        6'h20
`define SSRP_SYSCFG_RST      14'h0A00
`define SSRP_POR_RST         8'h00

// ==========================================================
// Timing
`define SSRP_CLK_PERIOD_NS   4
`define SSRP_MEAS_TIME_NS    500
`define SSRP_MEAS_CYC        ((`SSRP_MEAS_TIME_NS + `SSRP_CLK_PERIOD_NS - 1) / `SSRP_CLK_PERIOD_NS)

`endif
